// *** verilog/pssfs_params.svh ***
`ifndef PSSFS_PARAMS_SVH
`define PSSFS_PARAMS_SVH

// Ramp timebase: 220 nF node, 125 MHz clock
`define PSSFS_CLK_MHZ 125
// Soft-start about 2 ms, split over one ramp segment
`define PSSFS_SOFTSTART_US 2000
`define PSSFS_SOFTSTART_CYC ((`PSSFS_SOFTSTART_US * `PSSFS_CLK_MHZ))
// Fault time-out about 50 ms
`define PSSFS_TIMEOUT_US 50000
`define PSSFS_TIMEOUT_CYC ((`PSSFS_TIMEOUT_US * `PSSFS_CLK_MHZ))
// Default length of one ordinary ramp segment
`define PSSFS_SEG_US 1000
`define PSSFS_SEG_CYC ((`PSSFS_SEG_US * `PSSFS_CLK_MHZ))
// Segment count: six peaks, rise and fall each
`define PSSFS_NUM_SEG 12
`define PSSFS_CNT_W 24
// Segment indices where events occur (0 = first rise)
`define PSSFS_SEG_SELFTEST_END 4
`define PSSFS_SEG_REFCHK 2
`define PSSFS_SEG_SOFTSTART 4
`define PSSFS_SEG_NEG_ON 6
`define PSSFS_SEG_GATE_ON 8
`define PSSFS_SEG_POS_ON 10
`define PSSFS_SEG_FINAL 11

`endif

// *** verilog/pssfs_pkg.sv ***
package pssfs_pkg;
    typedef enum logic [2:0] {
        PSSFS_OFF,
        PSSFS_RAMP,
        PSSFS_RUN,
        PSSFS_TIMEOUT,
        PSSFS_LATCHED
    } pssfs_state_t;

    // Monitor inputs, high means a fault seen
    typedef struct packed {
        logic timing_stuck_low;
        logic timing_stuck_high;
        logic ref_bad;
        logic over_temp;
        logic boost_rail_low;
        logic negative_rail_low;
        logic positive_rail_low;
        logic logic_rail_low;
        logic gate_not_low;
    } pssfs_mon_t;

    typedef struct packed {
        logic analog_boost_rail;
        logic negative_gate_rail;
        logic delayed_boost_gate;
        logic positive_gate_rail;
    } pssfs_en_t;

    typedef struct packed {
        logic immediate;
        logic timeout;
    } pssfs_fault_t;

    // Rail high flags, high means driven above target
    typedef struct packed {
        logic analog_boost_rail;
        logic negative_gate_rail;
        logic positive_gate_rail;
        logic logic_rail;
    } pssfs_over_t;
endpackage

// *** verilog/pssfs_timer.sv ***
`timescale 1ns/1ps
`include "pssfs_params.svh"

module pssfs_timer (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_run,
    input wire logic [`PSSFS_CNT_W+1:0] i_limit,
    output logic o_done
);
    logic [`PSSFS_CNT_W+1:0] count;
    wire at_limit = (count >= i_limit - 1'b1);

    // Clear waits for the enable too, so a frozen block keeps its place
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_clear) begin
                count <= '0;
            end else if (i_run && !at_limit) begin
                count <= count + 1'b1;
            end
        end
    end

    assign o_done = i_run && at_limit;
endmodule // pssfs_timer

// *** verilog/pssfs_sequencer.sv ***
`timescale 1ns/1ps
`include "pssfs_params.svh"
// What this block does
// - Main enable low keeps every sequenced output off.
// - Enable high and supply above 2.5V starts the first ramp.
// - Ramp waits for enable when supply is already good.
// - First four segments self-test timing node and reference; fault powers down.
// - Second ramp checks reference within 20% and temperature; else latch.
// - Boost soft-start begins at third ramp, about 2 ms.
// - Negative gate rail enabled at start of fourth ramp.
// - Delayed-boost gate pulled low at start of fifth ramp.
// - Positive rail at sixth ramp; rails checked at its end.
// - Successful start-up shows exactly six peaks.
// - Any shutdown latches until enable toggles or supply cycles.
// - Logic rail follows its own enable only.
// - Timing node stuck low never starts; stuck high never completes.
// - After start-up monitor all inputs, timing node held at 1.15V.
// - Timing node, reference or temperature fault shuts down at once.
// - Other faults run a time-out ramp; reaching threshold latches off.
// - Fault clearing before time-out returns to normal running.
// - Gate not below 0.6V after start-up is a fault.
// - Rail above target switches off its drive, no shutdown.
// - Current-limited rail low starts time-out; persistent fault disables.
// - Die above 140C is over-temperature and shuts down.
// - Fault time-out about 50 ms.

module pssfs_sequencer #(
    parameter int unsigned SEG_CYC = `PSSFS_SEG_CYC,
    parameter int unsigned SOFTSTART_CYC = `PSSFS_SOFTSTART_CYC,
    parameter int unsigned TIMEOUT_CYC = `PSSFS_TIMEOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_main_enable,
    input wire logic i_supply_good,
    input wire logic i_logic_rail_enable,
    input wire pssfs_pkg::pssfs_mon_t i_mon,
    input wire pssfs_pkg::pssfs_over_t i_over,
    output pssfs_pkg::pssfs_en_t o_enable,
    output pssfs_pkg::pssfs_over_t o_drive,
    output logic o_logic_rail_on,
    output logic o_delayed_boost_gate_out,
    output logic o_delayed_boost_gate_oe,
    output logic o_peak,
    output logic o_timing_hold,
    output logic o_done,
    output pssfs_pkg::pssfs_fault_t o_fault,
    output pssfs_pkg::pssfs_state_t o_state
);
    pssfs_pkg::pssfs_state_t state;
    pssfs_pkg::pssfs_state_t next_state;
    pssfs_pkg::pssfs_en_t en;
    pssfs_pkg::pssfs_fault_t next_fault;
    logic [3:0] seg;
    logic [3:0] next_seg;
    logic timer_clear;
    logic timer_done;
    logic [`PSSFS_CNT_W+1:0] limit;

    // Per-phase duration; soft-start segment is the long one
    wire seg_is_soft = (seg == 4'(`PSSFS_SEG_SOFTSTART));
    wire [`PSSFS_CNT_W+1:0] seg_limit = seg_is_soft ? (`PSSFS_CNT_W+2)'(SOFTSTART_CYC)
                                                     : (`PSSFS_CNT_W+2)'(SEG_CYC);
    assign limit = (state == pssfs_pkg::PSSFS_TIMEOUT) ? (`PSSFS_CNT_W+2)'(TIMEOUT_CYC)
                                                       : seg_limit;

    wire seg_end = timer_done;
    wire rising = !seg[0];
    wire start_ok = i_main_enable && i_supply_good && !i_mon.timing_stuck_low;
    // Self-test window faults
    wire selftest_fault = (seg < 4'(`PSSFS_SEG_SELFTEST_END))
        && (i_mon.timing_stuck_low || i_mon.ref_bad);
    // Stuck-high node stops the ramp timer in every ramp segment
    wire stuck_high_block = i_mon.timing_stuck_high;
    wire refchk_fault = ((seg == 4'(`PSSFS_SEG_REFCHK)) || (seg == 4'(`PSSFS_SEG_REFCHK + 1)))
        && (i_mon.ref_bad || i_mon.over_temp);
    wire final_fault = (seg == 4'(`PSSFS_SEG_FINAL)) && seg_end
        && (i_mon.boost_rail_low || i_mon.negative_rail_low
            || i_mon.positive_rail_low || i_mon.gate_not_low);
    wire immediate_fault = i_mon.timing_stuck_low || i_mon.timing_stuck_high
        || i_mon.ref_bad || i_mon.over_temp;
    wire timeout_cause = i_mon.boost_rail_low || i_mon.negative_rail_low
        || i_mon.positive_rail_low || i_mon.logic_rail_low
        || i_mon.gate_not_low;

    pssfs_timer u_timer (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_clear(timer_clear),
        .i_run((state == pssfs_pkg::PSSFS_RAMP && !stuck_high_block) ||
               state == pssfs_pkg::PSSFS_TIMEOUT),
        .i_limit(limit),
        .o_done(timer_done)
    );

    always_comb begin
        next_state = state;
        next_seg = seg;
        next_fault = o_fault;
        timer_clear = 1'b0;
        case (state)
            pssfs_pkg::PSSFS_OFF: begin
                timer_clear = 1'b1;
                next_seg = '0;
                if (start_ok) begin
                    next_state = pssfs_pkg::PSSFS_RAMP;
                end
            end
            pssfs_pkg::PSSFS_RAMP: begin
                if (selftest_fault || refchk_fault || final_fault) begin
                    next_state = pssfs_pkg::PSSFS_LATCHED;
                    next_fault.immediate = selftest_fault || refchk_fault;
                    next_fault.timeout = final_fault;
                end else if (seg_end) begin
                    timer_clear = 1'b1;
                    if (seg == 4'(`PSSFS_SEG_FINAL)) begin
                        next_state = pssfs_pkg::PSSFS_RUN;
                    end else begin
                        next_seg = seg + 4'h1;
                    end
                end
            end
            pssfs_pkg::PSSFS_RUN: begin
                timer_clear = 1'b1;
                if (immediate_fault) begin
                    next_state = pssfs_pkg::PSSFS_LATCHED;
                    next_fault.immediate = 1'b1;
                end else if (timeout_cause) begin
                    next_state = pssfs_pkg::PSSFS_TIMEOUT;
                end
            end
            pssfs_pkg::PSSFS_TIMEOUT: begin
                if (immediate_fault) begin
                    next_state = pssfs_pkg::PSSFS_LATCHED;
                    next_fault.immediate = 1'b1;
                end else if (!timeout_cause) begin
                    next_state = pssfs_pkg::PSSFS_RUN;
                end else if (timer_done) begin
                    next_state = pssfs_pkg::PSSFS_LATCHED;
                    next_fault.timeout = 1'b1;
                end
            end
            pssfs_pkg::PSSFS_LATCHED: begin
                timer_clear = 1'b1;
                // Only an enable low or supply loss releases, handled below
                next_state = pssfs_pkg::PSSFS_LATCHED;
            end
            default: begin
                next_state = pssfs_pkg::PSSFS_OFF;
            end
        endcase
        // Enable low or supply gone powers down and releases the latch
        if (!i_main_enable || !i_supply_good) begin
            next_state = pssfs_pkg::PSSFS_OFF;
            next_fault = '0;
            timer_clear = 1'b1;
        end
    end

    // Enables as a function of segment reached
    wire past_seq = (state == pssfs_pkg::PSSFS_RUN) || (state == pssfs_pkg::PSSFS_TIMEOUT);
    // Enable or supply loss drops every sequenced rail on the same edge as the state
    wire active = (past_seq || (state == pssfs_pkg::PSSFS_RAMP))
        && i_main_enable && i_supply_good;
    always_comb begin
        en.analog_boost_rail = active && (past_seq || seg >= 4'(`PSSFS_SEG_SOFTSTART));
        en.negative_gate_rail = active && (past_seq || seg >= 4'(`PSSFS_SEG_NEG_ON));
        en.delayed_boost_gate = active && (past_seq || seg >= 4'(`PSSFS_SEG_GATE_ON));
        en.positive_gate_rail = active && (past_seq || seg >= 4'(`PSSFS_SEG_POS_ON));
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= pssfs_pkg::PSSFS_OFF;
            seg <= 4'h0;
            o_fault <= '0;
            o_enable <= '0;
            o_drive <= '0;
            o_logic_rail_on <= 1'b0;
            o_delayed_boost_gate_out <= 1'b0;
            o_delayed_boost_gate_oe <= 1'b0;
            o_peak <= 1'b0;
            o_timing_hold <= 1'b0;
            o_done <= 1'b0;
            o_state <= pssfs_pkg::PSSFS_OFF;
        end else if (i_ce) begin
            state <= next_state;
            seg <= next_seg;
            o_fault <= next_fault;
            o_enable <= en;
            // Over-target rail loses its drive only while high
            o_drive.analog_boost_rail <= en.analog_boost_rail && !i_over.analog_boost_rail;
            o_drive.negative_gate_rail <= en.negative_gate_rail
                && !i_over.negative_gate_rail;
            o_drive.positive_gate_rail <= en.positive_gate_rail
                && !i_over.positive_gate_rail;
            o_drive.logic_rail <= i_logic_rail_enable && !i_over.logic_rail;
            o_logic_rail_on <= i_logic_rail_enable;
            o_delayed_boost_gate_out <= 1'b0;
            o_delayed_boost_gate_oe <= en.delayed_boost_gate;
            // One pulse at the top of each rising segment
            o_peak <= (state == pssfs_pkg::PSSFS_RAMP) && rising && seg_end
                && !selftest_fault && !refchk_fault;
            o_timing_hold <= (state == pssfs_pkg::PSSFS_RUN);
            o_done <= past_seq;
            o_state <= next_state;
        end
    end
endmodule // pssfs_sequencer

// *** tb/pssfs_properties.sv ***
`timescale 1ns/1ps
module pssfs_properties #(
    parameter int unsigned TIMEOUT_CYC = 32
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_main_enable,
    input wire logic i_supply_good,
    input wire logic i_logic_rail_enable,
    input wire pssfs_pkg::pssfs_mon_t i_mon,
    input wire pssfs_pkg::pssfs_over_t i_over,
    input wire pssfs_pkg::pssfs_en_t o_enable,
    input wire pssfs_pkg::pssfs_over_t o_drive,
    input wire logic o_logic_rail_on,
    input wire logic o_delayed_boost_gate_out,
    input wire logic o_peak,
    input wire pssfs_pkg::pssfs_fault_t o_fault,
    input wire pssfs_pkg::pssfs_state_t o_state
);
    localparam int TO_MAX = TIMEOUT_CYC + 4;
    wire logic run = o_state == pssfs_pkg::PSSFS_RUN;
    wire logic latched = o_state == pssfs_pkg::PSSFS_LATCHED;
    wire logic wait_out = o_state == pssfs_pkg::PSSFS_TIMEOUT;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_off_when_disabled: assert property (i_ce && !i_main_enable |=> o_enable == 4'h0)
        else $error("enables on while disabled");
    a_ramp_starts: assert property (i_ce && i_main_enable && i_supply_good
        && o_state == pssfs_pkg::PSSFS_OFF && !i_mon.timing_stuck_low
        |=> o_state == pssfs_pkg::PSSFS_RAMP) else $error("ramp did not start");
    a_logic_follows: assert property (i_ce |=> o_logic_rail_on == $past(i_logic_rail_enable))
        else $error("logic rail not following its enable");
    a_gate_open_drain: assert property (o_delayed_boost_gate_out == 1'b0)
        else $error("gate pin driven high");
    a_rail_order: assert property (o_enable.positive_gate_rail |-> o_enable.negative_gate_rail
        && o_enable.analog_boost_rail && o_enable.delayed_boost_gate) else $error("rail order");
    a_peak_pulse: assert property (o_peak |=> !o_peak)
        else $error("peak longer than one cycle");
    a_over_cuts_drive: assert property (i_ce && i_over.positive_gate_rail
        |=> !o_drive.positive_gate_rail) else $error("drive kept above target");
    a_timeout_bounded: assert property (i_ce && wait_out |-> ##[1:TO_MAX] !wait_out)
        else $error("time-out ramp overran");
    a_hot_immediate: assert property (i_ce && i_main_enable && i_supply_good && run
        && i_mon.over_temp |=> latched && o_fault.immediate) else $error("no immediate stop");
    a_latch_holds_off: assert property (latched && $past(latched) |-> o_enable == 4'h0)
        else $error("enables on while latched");
endmodule // pssfs_properties

bind pssfs_sequencer pssfs_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_main_enable(i_main_enable),
    .i_supply_good(i_supply_good), .i_logic_rail_enable(i_logic_rail_enable),
    .i_mon(i_mon), .i_over(i_over), .o_enable(o_enable), .o_drive(o_drive),
    .o_logic_rail_on(o_logic_rail_on), .o_delayed_boost_gate_out(o_delayed_boost_gate_out),
    .o_peak(o_peak), .o_fault(o_fault), .o_state(o_state));

// *** tb/pssfs_rail_model.sv ***
`timescale 1ns/1ps
module pssfs_rail_model (
    input wire pssfs_pkg::pssfs_mon_t i_inject,
    input wire pssfs_pkg::pssfs_en_t i_enable,
    input wire logic i_logic_on,
    input wire logic i_gate_oe,
    input wire logic i_done,
    output pssfs_pkg::pssfs_mon_t o_mon
);
    // Undriven rails sit at 0 V, so they read low, as on a real board
    assign o_mon = i_inject | {4'h0, !i_enable.analog_boost_rail,
        !i_enable.negative_gate_rail, !i_enable.positive_gate_rail, !i_logic_on,
        i_done && !i_gate_oe};
endmodule // pssfs_rail_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    localparam int unsigned SEG = 8;
    localparam int unsigned SOFT = 16;
    localparam int unsigned TMO = 32;
    localparam pssfs_pkg::pssfs_state_t RUN = pssfs_pkg::PSSFS_RUN;
    localparam pssfs_pkg::pssfs_state_t LATCH = pssfs_pkg::PSSFS_LATCHED;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_ce = 1'b1;
    logic i_main_enable = 1'b0;
    logic i_supply_good = 1'b0;
    logic i_logic_rail_enable = 1'b0;
    pssfs_pkg::pssfs_mon_t inject = '0;
    pssfs_pkg::pssfs_mon_t i_mon;
    pssfs_pkg::pssfs_over_t i_over = '0;
    pssfs_pkg::pssfs_over_t o_drive;
    pssfs_pkg::pssfs_en_t o_enable;
    pssfs_pkg::pssfs_fault_t o_fault;
    pssfs_pkg::pssfs_state_t o_state;
    logic o_logic_rail_on, o_gate_out, o_gate_oe, o_peak, o_timing_hold, o_done;
    int num_errors = 0;
    int checks = 0;

    pssfs_sequencer #(.SEG_CYC(SEG), .SOFTSTART_CYC(SOFT), .TIMEOUT_CYC(TMO)) uut (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_main_enable(i_main_enable),
        .i_supply_good(i_supply_good), .i_logic_rail_enable(i_logic_rail_enable),
        .i_mon(i_mon), .i_over(i_over), .o_enable(o_enable), .o_drive(o_drive),
        .o_logic_rail_on(o_logic_rail_on), .o_delayed_boost_gate_out(o_gate_out),
        .o_delayed_boost_gate_oe(o_gate_oe), .o_peak(o_peak), .o_timing_hold(o_timing_hold),
        .o_done(o_done), .o_fault(o_fault), .o_state(o_state));
    pssfs_rail_model far_side (.i_inject(inject), .i_enable(o_enable),
        .i_logic_on(o_logic_rail_on), .i_gate_oe(o_gate_oe), .i_done(o_done), .o_mon(i_mon));

    initial begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_hold();
        i_supply_good = 1'b1;
        i_logic_rail_enable = 1'b1;
        step(20);
        chk(o_state, pssfs_pkg::PSSFS_OFF);
        chk(o_enable, 4'h0);
        chk(o_logic_rail_on, 1'b1);
        $display("test hold done");
    endtask
    task automatic t_startup();
        int n;
        int pk = 0;
        int pk_boost = -1;
        int t_boost = 0;
        int t_neg = 0;
        int t_gate = 0;
        int t_pos = 0;
        i_main_enable = 1'b1;
        // Enable times are judged only as spacings, so a fixed output latency cancels out
        for (n = 1; n < 400 && o_done !== 1'b1; n++) begin
            step(1);
            pk += (o_peak === 1'b1);
            if (o_enable.analog_boost_rail === 1'b1 && t_boost == 0) t_boost = n;
            if (t_boost == n) pk_boost = pk;
            if (o_enable.negative_gate_rail === 1'b1 && t_neg == 0) t_neg = n;
            if (o_enable.delayed_boost_gate === 1'b1 && t_gate == 0) t_gate = n;
            if (o_enable.positive_gate_rail === 1'b1 && t_pos == 0) t_pos = n;
        end
        if (o_done !== 1'b1) begin
            num_errors++;
            close_out();
        end
        chk(pk_boost, 2);
        chk(t_neg - t_boost, SOFT + SEG);
        chk(t_gate - t_neg, 2 * SEG);
        chk(t_pos - t_gate, 2 * SEG);
        chk(pk, 6);
        chk(o_gate_oe, 1'b1);
        chk(o_timing_hold, 1'b1);
        chk(o_fault, 2'h0);
        $display("test startup done");
    endtask
    task automatic t_over();
        i_over.positive_gate_rail = 1'b1;
        step(3);
        chk(o_drive.positive_gate_rail, 1'b0);
        chk(o_state, RUN);
        i_over = '0;
        step(3);
        chk(o_drive.positive_gate_rail, 1'b1);
        $display("test over done");
    endtask
    task automatic t_freeze();
        i_ce = 1'b0;
        inject.boost_rail_low = 1'b1;
        step(4);
        chk(o_state, RUN);
        inject = '0;
        i_ce = 1'b1;
        step(2);
        chk(o_state, RUN);
        $display("test freeze done");
    endtask
    task automatic t_blip();
        inject.boost_rail_low = 1'b1;
        step(TMO / 2);
        chk(o_state, pssfs_pkg::PSSFS_TIMEOUT);
        inject = '0;
        step(3);
        chk(o_state, RUN);
        chk(o_fault, 2'h0);
        $display("test blip done");
    endtask
    task automatic t_persist();
        int n;
        inject.negative_rail_low = 1'b1;
        for (n = 0; n < TMO + 10 && o_state !== LATCH; n++) step(1);
        chk(n >= TMO - 2 && n < TMO + 10, 1'b1);
        chk(o_fault, 2'h1);
        inject = '0;
        step(5);
        chk(o_state, LATCH);
        i_main_enable = 1'b0;
        step(2);
        chk(o_fault, 2'h0);
        t_startup();
        $display("test persist done");
    endtask
    task automatic t_hot();
        inject.over_temp = 1'b1;
        step(2);
        chk(o_state, LATCH);
        chk(o_fault, 2'h2);
        inject = '0;
        i_supply_good = 1'b0;
        step(2);
        chk(o_enable, 4'h0);
        i_supply_good = 1'b1;
        t_startup();
        $display("test hot done");
    endtask
    task automatic t_refbad();
        i_main_enable = 1'b0;
        inject.ref_bad = 1'b1;
        step(2);
        i_main_enable = 1'b1;
        step(4 * SEG + 2);
        chk(o_state, LATCH);
        chk(o_enable, 4'h0);
        $display("test refbad done");
    endtask
    task automatic t_stuck();
        pssfs_pkg::pssfs_mon_t bad[2] = '{9'h100, 9'h080};
        foreach (bad[k]) begin
            i_main_enable = 1'b0;
            inject = bad[k];
            step(2);
            i_main_enable = 1'b1;
            step(12 * SEG + SOFT);
            chk(o_done, 1'b0);
        end
        $display("test stuck done");
    endtask
    initial begin
        step(10);
        i_reset = 1'b0;
        t_hold();
        t_startup();
        t_over();
        t_freeze();
        t_blip();
        t_persist();
        t_hot();
        t_refbad();
        t_stuck();
        close_out();
    end
endmodule // tb
